// file: src/asp_top.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module asp_top #(
	parameter int OVS = 16
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// register bus
	input wire asp_pkg::asp_axi_req_t AXI_REQ,
	output asp_pkg::asp_axi_rsp_t AXI_RSP,
	// serial link
	input wire logic SERIAL_IN_PIN,
	output logic SERIAL_OUT_PIN,
	// interrupt request
	output logic IRQ
);
	import asp_pkg::*;

	localparam logic [7:0] SUB_LAST = 8'(OVS - 1);
	localparam logic [7:0] SUB_MID = 8'(OVS / 2 - 1);

	if (OVS < 4 || OVS > 256) begin : g_bad_ovs
		$error("OVS must lie in 4..256");
	end

	asp_state_t s;
	asp_state_t next_s;

	// =====================================================
	// outputs
	assign AXI_RSP.awready = !s.aw_got && !s.bvalid;
	assign AXI_RSP.wready = !s.w_got && !s.bvalid;
	assign AXI_RSP.bvalid = s.bvalid;
	assign AXI_RSP.bresp = s.bresp;
	assign AXI_RSP.arready = !s.rvalid;
	assign AXI_RSP.rvalid = s.rvalid;
	assign AXI_RSP.rdata = {24'h000000, s.rdata};
	assign AXI_RSP.rresp = s.rresp;
	assign SERIAL_OUT_PIN = s.tx_line;
	assign IRQ = (s.ctl[CTL_TXDONE_EN] && s.tx_complete_flag)
		|| (s.ctl[CTL_RXERR_EN] && (s.framing_flag || s.parity_error_flag || s.overrun_flag))
		|| (s.ctl[CTL_RXFULL_EN] && (s.ctl[CTL_THRESHOLD] ? s.rx_count == FIFO_DEPTH
			: s.rx_count != 2'h0))
		|| (s.ctl[CTL_TXEMPTY_EN] && s.tx_holding_empty);

	// =====================================================
	// next state
	always_comb begin
		logic [11:0] f;
		logic [3:0] nd;
		logic [7:0] dmask;
		logic par;
		logic tx_done;
		logic rx_land;
		logic [7:0] wd;
		next_s = s;
		f = 12'hFFF;
		tx_done = 1'b0;
		rx_land = 1'b0;
		wd = s.w_data;
		nd = s.fmt[FMT_LEN8] ? 4'h8 : 4'h7;
		dmask = s.fmt[FMT_LEN8] ? 8'hFF : 8'h7F;
		par = 1'b0;

		// baud tick: the fine-adjust pattern and clock source select are held but not applied
		next_s.tick = 1'b0;
		if (s.clkc[CLK_GATE]) begin
			if (s.baud_cnt == 8'h00) begin
				next_s.baud_cnt = s.baud;
				next_s.tick = 1'b1;
			end else begin
				next_s.baud_cnt = s.baud_cnt - 8'h01;
			end
		end

		// input synchroniser
		next_s.sin_meta = SERIAL_IN_PIN;
		next_s.sin_sync = s.sin_meta;
		next_s.sin_prev = s.sin_sync;

		// transmitter; runs before the bus so a same-cycle data write refills the buffer
		unique case (s.tx_st)
			TX_IDLE: begin
				if (s.ctl[CTL_PORT_EN] && !s.tx_holding_empty) begin
					f[0] = 1'b0;
					for (int i = 0; i < 8; i++) begin
						if (i < int'(nd)) begin
							f[i + 1] = s.tx_data[i];
						end
					end
					par = ^(s.tx_data & dmask) ^ s.fmt[FMT_ODD];
					if (s.fmt[FMT_PAR_EN]) begin
						f[int'(nd) + 1] = par;
					end
					next_s.tx_frame = f;
					next_s.tx_left = 4'h2 + nd + {3'h0, s.fmt[FMT_PAR_EN]} + {3'h0, s.fmt[FMT_STOP2]};
					next_s.tx_sub = 8'h00;
					next_s.tx_holding_empty = 1'b1;
					next_s.tx_shifter_busy = 1'b1;
					next_s.tx_st = TX_RUN;
				end
			end
			TX_RUN: begin
				if (s.tick) begin
					if (s.tx_sub == SUB_LAST) begin
						next_s.tx_sub = 8'h00;
						next_s.tx_frame = {1'b1, s.tx_frame[11:1]};
						next_s.tx_left = s.tx_left - 4'h1;
						if (s.tx_left == 4'h1) begin
							next_s.tx_shifter_busy = 1'b0;
							tx_done = 1'b1;
							next_s.tx_st = TX_IDLE;
						end
					end else begin
						next_s.tx_sub = s.tx_sub + 8'h01;
					end
				end
			end
		endcase

		// write address and data, taken in either order
		if (AXI_REQ.awvalid && !s.aw_got && !s.bvalid) begin
			next_s.aw_got = 1'b1;
			next_s.aw_idx = AXI_REQ.awaddr[ADDR_W-1:2];
		end
		if (AXI_REQ.wvalid && !s.w_got && !s.bvalid) begin
			next_s.w_got = 1'b1;
			next_s.w_data = AXI_REQ.wdata[7:0];
			next_s.w_lane = AXI_REQ.wstrb[0];
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			unique case (s.aw_idx)
				IDX_STATUS: begin
					if (s.w_lane) begin
						if (wd[ST_TXDONE]) next_s.tx_complete_flag = 1'b0;
						if (wd[ST_FRAME]) next_s.framing_flag = 1'b0;
						if (wd[ST_PARITY]) next_s.parity_error_flag = 1'b0;
						if (wd[ST_OVERRUN]) next_s.overrun_flag = 1'b0;
					end
				end
				IDX_TXD: begin
					if (s.w_lane) begin
						next_s.tx_data = wd;
						next_s.tx_holding_empty = 1'b0;
					end
				end
				IDX_RXD: begin
				end
				// reserved bits are masked so they always read back as zero
				IDX_FMT: begin
					if (s.w_lane) begin
						next_s.fmt = wd & FMT_MASK;
					end
				end
				IDX_CTL: begin
					if (s.w_lane) begin
						next_s.ctl = wd & CTL_MASK;
					end
				end
				IDX_IR: begin
					if (s.w_lane) begin
						next_s.ir = wd & IR_MASK;
					end
				end
				// storage only: the divider reload is picked up at the next underflow
				IDX_BAUD: begin
					if (s.w_lane) begin
						next_s.baud = wd;
					end
				end
				IDX_FINE: begin
					if (s.w_lane) begin
						next_s.fine = wd & FINE_MASK;
					end
				end
				IDX_CLK: begin
					if (s.w_lane) begin
						next_s.clkc = wd & CLK_MASK;
					end
				end
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		if (s.bvalid && AXI_REQ.bready) begin
			next_s.bvalid = 1'b0;
		end

		// read; a receive data read pops the fifo
		if (AXI_REQ.arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			unique case (AXI_REQ.araddr[ADDR_W-1:2])
				IDX_STATUS: next_s.rdata = {s.tx_complete_flag, s.framing_flag, s.parity_error_flag,
					s.overrun_flag, s.rx_count == FIFO_DEPTH, s.tx_shifter_busy,
					s.rx_count != 2'h0, s.tx_holding_empty};
				IDX_TXD: next_s.rdata = s.tx_data;
				IDX_RXD: begin
					next_s.rdata = s.rx_fifo0;
					if (s.rx_count != 2'h0) begin
						next_s.rx_fifo0 = s.rx_fifo1;
						next_s.rx_count = s.rx_count - 2'h1;
					end
				end
				IDX_FMT: next_s.rdata = s.fmt;
				IDX_CTL: next_s.rdata = s.ctl;
				IDX_IR: next_s.rdata = s.ir;
				IDX_BAUD: next_s.rdata = s.baud;
				IDX_FINE: next_s.rdata = s.fine;
				IDX_CLK: next_s.rdata = s.clkc;
				default: begin
					next_s.rdata = REG_RESET;
					next_s.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (s.rvalid && AXI_REQ.rready) begin
			next_s.rvalid = 1'b0;
		end

		// hardware sets land after software clears
		if (tx_done) begin
			next_s.tx_complete_flag = 1'b1;
		end

		// receiver, sampling mid-bit at OVS ticks per bit
		unique case (s.rx_st)
			RX_IDLE: begin
				if (s.ctl[CTL_PORT_EN] && s.sin_prev && !s.sin_sync) begin
					next_s.rx_st = RX_START;
					next_s.rx_sub = 8'h00;
					next_s.rx_bit = 4'h0;
					next_s.rx_shift = 8'h00;
				end
			end
			RX_START: begin
				if (s.tick) begin
					if (s.rx_sub == SUB_MID) begin
						next_s.rx_sub = 8'h00;
						next_s.rx_st = s.sin_sync ? RX_IDLE : RX_DATA;
					end else begin
						next_s.rx_sub = s.rx_sub + 8'h01;
					end
				end
			end
			RX_DATA, RX_PAR, RX_STOP: begin
				if (s.tick) begin
					if (s.rx_sub == SUB_LAST) begin
						next_s.rx_sub = 8'h00;
						if (s.rx_st == RX_DATA) begin
							next_s.rx_shift[s.rx_bit[2:0]] = s.sin_sync;
							next_s.rx_bit = s.rx_bit + 4'h1;
							if (s.rx_bit == nd - 4'h1) begin
								next_s.rx_st = s.fmt[FMT_PAR_EN] ? RX_PAR : RX_STOP;
							end
						end else if (s.rx_st == RX_PAR) begin
							next_s.rx_par_bit = s.sin_sync;
							next_s.rx_st = RX_STOP;
						end else begin
							// only the first stop bit is checked; a second one is idle time
							rx_land = 1'b1;
							next_s.rx_st = RX_IDLE;
							if (!s.sin_sync) begin
								next_s.framing_flag = 1'b1;
							end
						end
					end else begin
						next_s.rx_sub = s.rx_sub + 8'h01;
					end
				end
			end
			default: next_s.rx_st = RX_IDLE;
		endcase

		// fifo load, after any same-cycle pop
		if (rx_land) begin
			if (next_s.rx_count == FIFO_DEPTH) begin
				next_s.overrun_flag = 1'b1;
			end else begin
				if (next_s.rx_count == 2'h0) begin
					next_s.rx_fifo0 = s.rx_shift;
				end else begin
					next_s.rx_fifo1 = s.rx_shift;
				end
				next_s.rx_count = next_s.rx_count + 2'h1;
				if (s.fmt[FMT_PAR_EN] && (^s.rx_shift ^ s.rx_par_bit ^ s.fmt[FMT_ODD]) != 1'b0) begin
					next_s.parity_error_flag = 1'b1;
				end
			end
		end

		if (!s.ctl[CTL_PORT_EN]) begin
			next_s.tx_holding_empty = 1'b1;
		end
		next_s.tx_line = (next_s.tx_st == TX_RUN) ? next_s.tx_frame[0] : 1'b1;
	end

	// =====================================================
	// state register
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s <= '0;
			s.tx_holding_empty <= 1'b1;
			s.tx_line <= 1'b1;
			s.sin_meta <= 1'b1;
			s.sin_sync <= 1'b1;
			s.sin_prev <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

endmodule

// file: src/asp_pkg.sv
package asp_pkg;

	// =====================================================
	// bus geometry and register word indices
	localparam int ADDR_W = 18;
	localparam logic [15:0] IDX_STATUS = 16'h4100;
	localparam logic [15:0] IDX_TXD = 16'h4101;
	localparam logic [15:0] IDX_RXD = 16'h4102;
	localparam logic [15:0] IDX_FMT = 16'h4103;
	localparam logic [15:0] IDX_CTL = 16'h4104;
	localparam logic [15:0] IDX_IR = 16'h4105;
	localparam logic [15:0] IDX_BAUD = 16'h4106;
	localparam logic [15:0] IDX_FINE = 16'h4107;
	localparam logic [15:0] IDX_CLK = 16'h506C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// =====================================================
	// field positions and writable masks
	localparam int ST_TXDONE = 7;
	localparam int ST_FRAME = 6;
	localparam int ST_PARITY = 5;
	localparam int ST_OVERRUN = 4;
	localparam int FMT_LEN8 = 4;
	localparam int FMT_PAR_EN = 3;
	localparam int FMT_ODD = 2;
	localparam int FMT_STOP2 = 1;
	localparam int CTL_TXDONE_EN = 7;
	localparam int CTL_RXERR_EN = 6;
	localparam int CTL_RXFULL_EN = 5;
	localparam int CTL_TXEMPTY_EN = 4;
	localparam int CTL_THRESHOLD = 1;
	localparam int CTL_PORT_EN = 0;
	localparam int CLK_GATE = 0;
	localparam logic [7:0] FMT_MASK = 8'h1E;
	localparam logic [7:0] CTL_MASK = 8'hF3;
	localparam logic [7:0] IR_MASK = 8'h01;
	localparam logic [7:0] FINE_MASK = 8'h0F;
	localparam logic [7:0] CLK_MASK = 8'h3D;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;

	// =====================================================
	// types
	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} asp_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} asp_axi_rsp_t;

	typedef enum logic {TX_IDLE, TX_RUN} asp_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asp_rx_state_t;

	typedef struct packed {
		logic aw_got;
		logic [15:0] aw_idx;
		logic w_got;
		logic [7:0] w_data;
		logic w_lane;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic tx_complete_flag;
		logic framing_flag;
		logic parity_error_flag;
		logic overrun_flag;
		logic tx_holding_empty;
		logic tx_shifter_busy;
		logic [7:0] tx_data;
		logic [1:0] rx_count;
		logic [7:0] rx_fifo0;
		logic [7:0] rx_fifo1;
		logic [7:0] fmt;
		logic [7:0] ctl;
		logic [7:0] ir;
		logic [7:0] baud;
		logic [7:0] fine;
		logic [7:0] clkc;
		logic [7:0] baud_cnt;
		logic tick;
		logic sin_meta;
		logic sin_sync;
		logic sin_prev;
		asp_tx_state_t tx_st;
		logic [11:0] tx_frame;
		logic [3:0] tx_left;
		logic [7:0] tx_sub;
		logic tx_line;
		asp_rx_state_t rx_st;
		logic [7:0] rx_sub;
		logic [3:0] rx_bit;
		logic [7:0] rx_shift;
		logic rx_par_bit;
	} asp_state_t;

endpackage

// file: sim/asp_sva.sv
`timescale 1ns/1ps
module asp_sva #(
	parameter int OVS = 16
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// watched ports
	input wire asp_pkg::asp_axi_req_t AXI_REQ,
	input wire asp_pkg::asp_axi_rsp_t AXI_RSP,
	input wire logic SERIAL_IN_PIN,
	input wire logic SERIAL_OUT_PIN,
	input wire logic IRQ
);
	import asp_pkg::*;
	// ========
	// helpers
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic ar_take;
	logic aw_both;
	logic bad_idx;
	assign ar_take = AXI_REQ.arvalid && AXI_RSP.arready;
	assign aw_both = AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready;
	assign bad_idx = !((AXI_REQ.araddr[17:2] >= IDX_STATUS && AXI_REQ.araddr[17:2] <= IDX_FINE)
		|| AXI_REQ.araddr[17:2] == IDX_CLK);
	// ========
	// properties
	rd_answer_a: assert property (ar_take |=> AXI_RSP.rvalid) else $error("read answer late");
	rd_hold_a: assert property (AXI_RSP.rvalid && !AXI_REQ.rready |=> AXI_RSP.rvalid && $stable(AXI_RSP.rdata))
		else $error("read answer dropped");
	wr_hold_a: assert property (AXI_RSP.bvalid && !AXI_REQ.bready |=> AXI_RSP.bvalid && $stable(AXI_RSP.bresp))
		else $error("write answer dropped");
	wr_answer_a: assert property (aw_both |=> !AXI_RSP.bvalid ##1 AXI_RSP.bvalid) else $error("write answer timing");
	rd_upper_a: assert property (AXI_RSP.rvalid |-> AXI_RSP.rdata[31:8] == 24'h0) else $error("upper bits set");
	ar_block_a: assert property (AXI_RSP.rvalid |-> !AXI_RSP.arready) else $error("read taken while busy");
	unmapped_rd_a: assert property (ar_take && bad_idx |=> AXI_RSP.rresp == RESP_SLVERR && AXI_RSP.rdata == 32'h0)
		else $error("unmapped read not refused");
	mapped_rd_a: assert property (ar_take && !bad_idx |=> AXI_RSP.rresp == RESP_OKAY) else $error("mapped read refused");
	start_bit_a: assert property ($fell(SERIAL_OUT_PIN) |-> !SERIAL_OUT_PIN [*4]) else $error("start bit short");
	rd_done_c: cover property (AXI_RSP.rvalid && AXI_REQ.rready);
	wr_done_c: cover property (AXI_RSP.bvalid && AXI_REQ.bready);
	tx_start_c: cover property ($fell(SERIAL_OUT_PIN));
endmodule

bind asp_top asp_sva #(.OVS(OVS)) u_sva (.CLK(CLK), .RST_N(RST_N), .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP),
	.SERIAL_IN_PIN(SERIAL_IN_PIN), .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .IRQ(IRQ));

// file: sim/asp_remote.sv
`timescale 1ns/1ps
module asp_remote #(
	parameter int BT = 4
) (
	// clock
	input wire logic clk,
	// serial lines
	input wire logic line_in,
	output logic line_out
);
	logic [7:0] rx_byte;
	int rx_cnt;
	initial begin
		line_out = 1'b1;
		rx_cnt = 0;
		rx_byte = 8'h00;
	end
	// ========
	// frame sender, line idles high between frames
	task automatic send(input logic [7:0] d, input logic pe, input logic p, input logic stp);
		line_out <= 1'b0;
		repeat (BT) @(posedge clk);
		for (int k = 0; k < 8; k++) begin
			line_out <= d[k];
			repeat (BT) @(posedge clk);
		end
		if (pe) begin
			line_out <= p;
			repeat (BT) @(posedge clk);
		end
		line_out <= stp;
		repeat (BT) @(posedge clk);
		line_out <= 1'b1;
		repeat (2 * BT) @(posedge clk);
	endtask
	// ========
	// frame catcher, samples mid-bit, eight data bits only
	always begin
		@(negedge line_in);
		repeat (BT / 2) @(posedge clk);
		for (int k = 0; k < 8; k++) begin
			repeat (BT) @(posedge clk);
			rx_byte[k] = line_in;
		end
		rx_cnt++;
	end
endmodule

// file: sim/asp_top_tb.sv
`timescale 1ns/1ps
module asp_top_tb;
	import asp_pkg::*;
	logic CLK;
	logic RST_N;
	asp_axi_req_t q;
	asp_axi_rsp_t r;
	logic sin;
	logic sout;
	logic IRQ;
	int fails = 0;
	int n_tests = 0;
	// bit time is OVS ticks with baud 0
	asp_top #(.OVS(4)) DUT (.CLK(CLK), .RST_N(RST_N), .AXI_REQ(q), .AXI_RSP(r),
		.SERIAL_IN_PIN(sin), .SERIAL_OUT_PIN(sout), .IRQ(IRQ));
	asp_remote #(.BT(4)) P (.clk(CLK), .line_in(sout), .line_out(sin));
	initial CLK = 1'b0;
	always #5 CLK = ~CLK;
	// ========
	// bus tasks
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] d);
		@(posedge CLK);
		q.awvalid <= 1'b1;
		q.wvalid <= 1'b1;
		q.awaddr <= {i, 2'h0};
		q.wdata <= {24'h0, d};
		q.bready <= 1'b1;
		forever begin
			@(posedge CLK);
			if (r.awready) q.awvalid <= 1'b0;
			if (r.wready) q.wvalid <= 1'b0;
			if (r.bvalid) break;
		end
		q.bready <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] i, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
		@(posedge CLK);
		q.arvalid <= 1'b1;
		q.araddr <= {i, 2'h0};
		q.rready <= 1'b1;
		forever begin
			@(posedge CLK);
			if (r.arready) q.arvalid <= 1'b0;
			if (r.rvalid) break;
		end
		q.rready <= 1'b0;
		chk({r.rresp, r.rdata[7:0]}, {er, e});
	endtask
	task automatic complete_run();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ========
	// watchdog
	initial begin
		repeat (20000) @(posedge CLK);
		fails++;
		complete_run();
	end
	// ========
	// tests
	initial begin
		q = '0;
		q.wstrb = 4'hF;
		RST_N = 1'b0;
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		rd(IDX_STATUS, 8'h01);
		rd(IDX_FMT, 8'h00);
		rd(16'h4108, 8'h00, RESP_SLVERR);
		wr(IDX_CLK, 8'h01);
		wr(IDX_FMT, 8'h10);
		wr(IDX_CTL, 8'h01);
		wr(IDX_TXD, 8'hA5);
		wait (P.rx_cnt == 1);
		repeat (12) @(posedge CLK);
		chk({2'h0, P.rx_byte}, 10'h0A5);
		wr(IDX_STATUS, 8'h00);
		rd(IDX_STATUS, 8'h81);
		wr(IDX_STATUS, 8'h80);
		rd(IDX_STATUS, 8'h01);
		P.send(8'h3C, 1'b0, 1'b0, 1'b1);
		P.send(8'hC3, 1'b0, 1'b0, 1'b1);
		rd(IDX_STATUS, 8'h0B);
		rd(IDX_RXD, 8'h3C);
		rd(IDX_STATUS, 8'h03);
		rd(IDX_RXD, 8'hC3);
		rd(IDX_STATUS, 8'h01);
		for (int k = 1; k < 4; k++) P.send(8'(k * 17), 1'b0, 1'b0, 1'b1);
		rd(IDX_STATUS, 8'h1B);
		rd(IDX_RXD, 8'h11);
		rd(IDX_RXD, 8'h22);
		wr(IDX_STATUS, 8'h10);
		rd(IDX_STATUS, 8'h01);
		P.send(8'h5A, 1'b0, 1'b0, 1'b0);
		rd(IDX_STATUS, 8'h43);
		rd(IDX_RXD, 8'h5A);
		wr(IDX_STATUS, 8'h40);
		wr(IDX_CTL, 8'h00);
		wr(IDX_FMT, 8'h1C);
		wr(IDX_CTL, 8'h01);
		P.send(8'h01, 1'b1, 1'b1, 1'b1);
		rd(IDX_STATUS, 8'h23);
		chk({9'h0, IRQ}, 10'h000);
		wr(IDX_CTL, 8'h41);
		chk({9'h0, IRQ}, 10'h001);
		rd(IDX_RXD, 8'h01);
		wr(IDX_STATUS, 8'h20);
		chk({9'h0, IRQ}, 10'h000);
		wr(IDX_CTL, 8'h00);
		wr(IDX_FMT, 8'h00);
		wr(IDX_CTL, 8'h01);
		P.send(8'hFF, 1'b0, 1'b0, 1'b1);
		rd(IDX_RXD, 8'h7F);
		wr(IDX_CTL, 8'h00);
		wr(IDX_FMT, 8'h10);
		wr(IDX_CTL, 8'h22);
		wr(IDX_CTL, 8'h23);
		P.send(8'h11, 1'b0, 1'b0, 1'b1);
		chk({9'h0, IRQ}, 10'h000);
		P.send(8'h22, 1'b0, 1'b0, 1'b1);
		chk({9'h0, IRQ}, 10'h001);
		rd(IDX_RXD, 8'h11);
		rd(IDX_RXD, 8'h22);
		chk({9'h0, IRQ}, 10'h000);
		wr(IDX_CTL, 8'h00);
		wr(IDX_FMT, 8'h08);
		wr(IDX_CTL, 8'h01);
		wr(IDX_TXD, 8'h81);
		wait (P.rx_cnt == 2);
		repeat (12) @(posedge CLK);
		chk({2'h0, P.rx_byte}, 10'h081);
		wr(IDX_CTL, 8'h00);
		wr(IDX_TXD, 8'h55);
		rd(IDX_STATUS, 8'h81);
		repeat (60) @(posedge CLK);
		chk(10'(P.rx_cnt), 10'h002);
		complete_run();
	end
endmodule
